// File: rtl/dcw_pkg.sv
// constants shared by the drive control word decoder
package dcw_pkg;
    localparam logic [15:0] DCW_CTRL_PARAM_NUM = 16'h03C7;
    localparam logic [15:0] DCW_CTRL_RESET = 16'h0000;
    localparam int DCW_WORD_W = 16;
    localparam int DCW_SPD_W = 16;
    localparam logic [1:0] DCW_TEL_TYPE_MAX = 2'h2;
    localparam int DCW_BIT_ON = 0;
    localparam int DCW_BIT_NO_COAST = 1;
    localparam int DCW_BIT_NO_QUICK = 2;
    localparam int DCW_BIT_ENABLE_OP = 3;
    localparam int DCW_BIT_RAMP_RUN = 4;
    localparam int DCW_BIT_UNFREEZE = 5;
    localparam int DCW_BIT_SP_ENABLE = 6;
    localparam int DCW_BIT_FAULT_ACK = 7;
    localparam int DCW_BIT_JOG_POS = 8;
    localparam int DCW_BIT_JOG_NEG = 9;
    localparam int DCW_BIT_PLC_CTRL = 10;
    localparam int DCW_DIP_W = 8;
    localparam int DCW_DIP_FB_ON = 7;
    localparam int DCW_CLK_MHZ = 100;
    localparam int DCW_RAMP_STEP_US = 10;
    localparam int DCW_RAMP_DIV = DCW_RAMP_STEP_US * DCW_CLK_MHZ;
    localparam int DCW_DIV_W = 10;
    typedef enum logic [1:0] {
        DCW_FB_FROM_PARAM,
        DCW_FB_FORCED_OFF,
        DCW_FB_FORCED_ON
    } dcw_fb_src_t;
endpackage

// File: rtl/dcw_ramp.sv
// speed setpoint ramp generator with freeze, reset and jump behaviour
`timescale 1ns/100ps
module dcw_ramp (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic tick_in,
    input wire logic run_in,
    input wire logic unfreeze_in,
    input wire logic sp_enable_in,
    input wire logic signed [dcw_pkg::DCW_SPD_W-1:0] goal_in,
    input wire logic [dcw_pkg::DCW_SPD_W-1:0] accel_in,
    input wire logic [dcw_pkg::DCW_SPD_W-1:0] decel_in,
    output logic signed [dcw_pkg::DCW_SPD_W-1:0] speed_out
);
    import dcw_pkg::*;

    logic sp_enable_d_r;
    logic signed [DCW_SPD_W-1:0] ramp_tgt;

    // one step toward the target; rate picked by whether magnitude grows
    function automatic logic signed [DCW_SPD_W-1:0] step_to(
        input logic signed [DCW_SPD_W-1:0] cur,
        input logic signed [DCW_SPD_W-1:0] tgt,
        input logic [DCW_SPD_W-1:0] acc,
        input logic [DCW_SPD_W-1:0] dec);
        logic signed [DCW_SPD_W+1:0] diff;
        logic signed [DCW_SPD_W+1:0] rate;
        logic up;
        logic grow;
        diff = 18'(tgt) - 18'(cur);
        up = (diff > 0);
        grow = up ? (cur >= 0) : (cur <= 0);
        rate = grow ? $signed({2'b00, acc}) : $signed({2'b00, dec});
        if (up && diff > rate) begin
            step_to = DCW_SPD_W'(18'(cur) + rate);
        end else if (!up && -diff > rate) begin
            step_to = DCW_SPD_W'(18'(cur) - rate);
        end else begin
            step_to = tgt;
        end
    endfunction

    // ramp reset steers toward standstill with the deceleration rate
    assign ramp_tgt = run_in ? goal_in : '0;

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sp_enable_d_r <= 1'b0;
        end else begin
            sp_enable_d_r <= sp_enable_in;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            speed_out <= '0;
        end else if (!sp_enable_in) begin
            speed_out <= '0;
        end else if (!sp_enable_d_r) begin
            // jump ignores freeze on purpose: setpoint enable overrides it
            speed_out <= ramp_tgt;
        end else if (tick_in && unfreeze_in) begin
            speed_out <= step_to(speed_out, ramp_tgt, accel_in,
                decel_in);
        end
    end
endmodule

// File: rtl/dcw_decoder.sv
// drive control word decoder: telegram intake, bit decode, bus activation
//
// Overview of operation
// - Control word sits at a fixed slot of receive telegram types 0 to 2.
// - Other telegram data is applied before the control word is evaluated.
// - Bits 0 to 3 are on, no coast, no quick stop, enable operation.
// - Speed mode bit 4 one enables setpoints; zero ramps down at decel rate.
// - Bit 4 back to one accelerates at accel rate up to set speed.
// - Bit 5 one lets the ramp run; zero freezes ramp output.
// - Bit 6 one enables ramp setpoint inputs; zero deactivates them.
// - Rising edge of bit 7 acknowledges active faults; level does nothing.
// - Bit 8 feeds positive jog speed through the ramp as setpoint.
// - Bit 9 feeds negative jog speed through the ramp as setpoint.
// - Control word is evaluated only while bit 10 is one.
// - All fieldbus DIP switches off: activation comes from stored parameters.
// - Switch 8 off with another switch on deactivates every fieldbus.
// - Switch 8 on activates fitted module, else the onboard bus.
// - Network settings apply after save and reset; deactivation is immediate.
// - Dynamic addressing takes IP, mask, gateway from discovery by name.
// - Frozen ramp keeps speed even when bit 4 later clears.
// - Bit 6 clear forces zero without ramp; set jumps to set speed.
`timescale 1ns/100ps
module dcw_decoder (
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic speed_mode_in,
    input wire logic tel_valid_in,
    input wire logic [1:0] tel_type_in,
    input wire logic [dcw_pkg::DCW_WORD_W-1:0] tel_ctrl_word_in,
    input wire logic signed [dcw_pkg::DCW_SPD_W-1:0] tel_speed_in,
    input wire logic param_req_in,
    input wire logic param_we_in,
    input wire logic [15:0] param_number_in,
    input wire logic [dcw_pkg::DCW_WORD_W-1:0] param_wdata_in,
    input wire logic signed [dcw_pkg::DCW_SPD_W-1:0] jog_pos_speed_in,
    input wire logic signed [dcw_pkg::DCW_SPD_W-1:0] jog_neg_speed_in,
    input wire logic [dcw_pkg::DCW_SPD_W-1:0] accel_rate_in,
    input wire logic [dcw_pkg::DCW_SPD_W-1:0] decel_rate_in,
    input wire logic [dcw_pkg::DCW_DIP_W-1:0] fb_dip_in,
    input wire logic fb_module_present_in,
    input wire logic fb_param_active_in,
    input wire logic dyn_addr_in,
    input wire logic [31:0] static_ip_in,
    input wire logic [31:0] static_mask_in,
    input wire logic [31:0] static_gw_in,
    input wire logic dcp_valid_in,
    input wire logic dcp_name_match_in,
    input wire logic [31:0] dcp_ip_in,
    input wire logic [31:0] dcp_mask_in,
    input wire logic [31:0] dcp_gw_in,
    output logic param_ack_out,
    output logic param_err_out,
    output logic [dcw_pkg::DCW_WORD_W-1:0] param_rdata_out,
    output logic [dcw_pkg::DCW_WORD_W-1:0] ctrl_word_out,
    output logic plc_control_out,
    output logic cmd_on_out,
    output logic cmd_no_coast_out,
    output logic cmd_no_quick_out,
    output logic cmd_enable_op_out,
    output logic fault_ack_out,
    output logic jog_pos_out,
    output logic jog_neg_out,
    output logic signed [dcw_pkg::DCW_SPD_W-1:0] speed_setpoint_out,
    output logic fb_module_active_out,
    output logic fb_onboard_active_out,
    output dcw_pkg::dcw_fb_src_t fb_source_out,
    output logic [31:0] ip_addr_out,
    output logic [31:0] subnet_mask_out,
    output logic [31:0] gateway_out
);
    import dcw_pkg::*;

    logic rst_s1_r;
    logic rstn_r;
    logic [DCW_WORD_W-1:0] ctrl_word_r;
    logic [DCW_WORD_W-1:0] eval_word_r;
    logic signed [DCW_SPD_W-1:0] tel_speed_r;
    logic eval_pend_r;
    logic fault_bit_d_r;
    logic [DCW_DIV_W-1:0] div_cnt_r;
    logic ramp_tick;
    logic cfg_taken_r;
    logic cfg_fb_active_r;
    logic cfg_dyn_r;
    logic tel_ok;
    logic param_hit;
    logic ramp_run;
    logic ramp_unfreeze;
    logic ramp_sp_en;
    logic signed [DCW_SPD_W-1:0] ramp_goal;
    logic fb_enabled;
    dcw_fb_src_t fb_src;

    // bit test on a received or evaluated control word, used by every control word decode below
    function automatic logic cw_bit(input logic [DCW_WORD_W-1:0] w,
        input int idx);
        cw_bit = w[idx];
    endfunction

    // reset release through two flops
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_s1_r <= 1'b0;
            rstn_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rstn_r <= rst_s1_r;
        end
    end

    // telegram types above 2 carry no control word slot
    assign tel_ok = tel_valid_in && (tel_type_in <= DCW_TEL_TYPE_MAX);
    assign param_hit = (param_number_in == DCW_CTRL_PARAM_NUM);

    // received control word, from telegram slot or parameter write
    always_ff @(posedge sys_clk_in or negedge rstn_r) begin
        if (!rstn_r) begin
            ctrl_word_r <= DCW_CTRL_RESET;
        end else if (tel_ok) begin
            ctrl_word_r <= tel_ctrl_word_in;
        end else if (param_req_in && param_we_in && param_hit) begin
            ctrl_word_r <= param_wdata_in;
        end
    end

    // telegram data lands now, the word is evaluated one cycle later
    always_ff @(posedge sys_clk_in or negedge rstn_r) begin
        if (!rstn_r) begin
            tel_speed_r <= '0;
        end else if (tel_ok) begin
            tel_speed_r <= tel_speed_in;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_r) begin
        if (!rstn_r) begin
            eval_pend_r <= 1'b0;
        end else begin
            eval_pend_r <= tel_ok ||
                (param_req_in && param_we_in && param_hit);
        end
    end

    // evaluated word keeps its other bits while plc control is off; only bit 10 clears
    always_ff @(posedge sys_clk_in or negedge rstn_r) begin
        if (!rstn_r) begin
            eval_word_r <= DCW_CTRL_RESET;
        end else if (eval_pend_r) begin
            if (cw_bit(ctrl_word_r, DCW_BIT_PLC_CTRL)) begin
                eval_word_r <= ctrl_word_r;
            end else begin
                // only the control flag follows; other bits ignored
                eval_word_r[DCW_BIT_PLC_CTRL] <= 1'b0;
            end
        end
    end

    assign plc_control_out = cw_bit(eval_word_r, DCW_BIT_PLC_CTRL);
    assign ctrl_word_out = ctrl_word_r;

    // state machine commands, passed to the device control logic
    assign cmd_on_out = cw_bit(eval_word_r, DCW_BIT_ON);
    assign cmd_no_coast_out = cw_bit(eval_word_r, DCW_BIT_NO_COAST);
    assign cmd_no_quick_out = cw_bit(eval_word_r, DCW_BIT_NO_QUICK);
    assign cmd_enable_op_out = cw_bit(eval_word_r, DCW_BIT_ENABLE_OP);

    // fault acknowledge on the rising edge of the evaluated bit only
    always_ff @(posedge sys_clk_in or negedge rstn_r) begin
        if (!rstn_r) begin
            fault_bit_d_r <= 1'b0;
        end else begin
            fault_bit_d_r <= cw_bit(eval_word_r, DCW_BIT_FAULT_ACK);
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_r) begin
        if (!rstn_r) begin
            fault_ack_out <= 1'b0;
        end else begin
            fault_ack_out <= cw_bit(eval_word_r, DCW_BIT_FAULT_ACK) &&
                !fault_bit_d_r;
        end
    end

    // ramp bits only mean something in speed mode; elsewhere ramp runs free
    assign ramp_run = !speed_mode_in ||
        cw_bit(eval_word_r, DCW_BIT_RAMP_RUN);
    assign ramp_unfreeze = !speed_mode_in ||
        cw_bit(eval_word_r, DCW_BIT_UNFREEZE);
    assign ramp_sp_en = !speed_mode_in ||
        cw_bit(eval_word_r, DCW_BIT_SP_ENABLE);
    assign jog_pos_out = speed_mode_in &&
        cw_bit(eval_word_r, DCW_BIT_JOG_POS);
    assign jog_neg_out = speed_mode_in &&
        cw_bit(eval_word_r, DCW_BIT_JOG_NEG);

    // both jogs at once cancel out to standstill rather than pick a side
    always_comb begin
        if (jog_pos_out && jog_neg_out) begin
            ramp_goal = '0;
        end else if (jog_pos_out) begin
            ramp_goal = jog_pos_speed_in;
        end else if (jog_neg_out) begin
            ramp_goal = jog_neg_speed_in;
        end else begin
            ramp_goal = tel_speed_r;
        end
    end
    // bits 11 to 15 reach no decode and raise no error

    // ramp step enable from a divider
    assign ramp_tick = (div_cnt_r == DCW_DIV_W'(DCW_RAMP_DIV - 1));

    always_ff @(posedge sys_clk_in or negedge rstn_r) begin
        if (!rstn_r) begin
            div_cnt_r <= '0;
        end else if (ramp_tick) begin
            div_cnt_r <= '0;
        end else begin
            div_cnt_r <= div_cnt_r + 1'b1;
        end
    end

    dcw_ramp dcw_ramp_inst (
        .clk_in(sys_clk_in),
        .rstn_in(rstn_r),
        .tick_in(ramp_tick),
        .run_in(ramp_run),
        .unfreeze_in(ramp_unfreeze),
        .sp_enable_in(ramp_sp_en),
        .goal_in(ramp_goal),
        .accel_in(accel_rate_in),
        .decel_in(decel_rate_in),
        .speed_out(speed_setpoint_out)
    );

    // parameter access answers one cycle after the request
    always_ff @(posedge sys_clk_in or negedge rstn_r) begin
        if (!rstn_r) begin
            param_ack_out <= 1'b0;
            param_err_out <= 1'b0;
            param_rdata_out <= '0;
        end else begin
            param_ack_out <= param_req_in;
            param_err_out <= param_req_in && !param_hit;
            if (param_req_in && !param_we_in && param_hit) begin
                param_rdata_out <= ctrl_word_r;
            end
        end
    end

    // stored network settings are caught once, just after reset release
    always_ff @(posedge sys_clk_in or negedge rstn_r) begin
        if (!rstn_r) begin
            cfg_taken_r <= 1'b0;
            cfg_fb_active_r <= 1'b0;
            cfg_dyn_r <= 1'b0;
        end else if (!cfg_taken_r) begin
            cfg_taken_r <= 1'b1;
            cfg_fb_active_r <= fb_param_active_in;
            cfg_dyn_r <= dyn_addr_in;
        end else if (!fb_param_active_in) begin
            cfg_fb_active_r <= 1'b0; // off stays off until reset
        end
    end

    // a live deactivation wins at once; activation waits for a reset
    assign fb_enabled = cfg_fb_active_r && fb_param_active_in;

    always_comb begin
        if (fb_dip_in == '0) begin
            fb_src = DCW_FB_FROM_PARAM;
        end else if (!fb_dip_in[DCW_DIP_FB_ON]) begin
            fb_src = DCW_FB_FORCED_OFF;
        end else begin
            fb_src = DCW_FB_FORCED_ON;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_r) begin
        if (!rstn_r) begin
            fb_source_out <= DCW_FB_FROM_PARAM;
            fb_module_active_out <= 1'b0;
            fb_onboard_active_out <= 1'b0;
        end else begin
            fb_source_out <= fb_src;
            case (fb_src)
                DCW_FB_FROM_PARAM: begin
                    fb_module_active_out <= fb_enabled &&
                        fb_module_present_in;
                    fb_onboard_active_out <= fb_enabled &&
                        !fb_module_present_in;
                end
                DCW_FB_FORCED_ON: begin
                    fb_module_active_out <= fb_module_present_in;
                    fb_onboard_active_out <= !fb_module_present_in;
                end
                default: begin
                    fb_module_active_out <= 1'b0;
                    fb_onboard_active_out <= 1'b0;
                end
            endcase
        end
    end

    // static address loads at start; discovery overwrites it when dynamic
    always_ff @(posedge sys_clk_in or negedge rstn_r) begin
        if (!rstn_r) begin
            ip_addr_out <= '0;
            subnet_mask_out <= '0;
            gateway_out <= '0;
        end else if (!cfg_taken_r) begin
            ip_addr_out <= static_ip_in;
            subnet_mask_out <= static_mask_in;
            gateway_out <= static_gw_in;
        end else if (cfg_dyn_r && dcp_valid_in && dcp_name_match_in) begin
            ip_addr_out <= dcp_ip_in;
            subnet_mask_out <= dcp_mask_in;
            gateway_out <= dcp_gw_in;
        end
    end
endmodule

// File: verification/dcw_master_model.sv
// fieldbus master model sending receive telegrams to the decoder
`timescale 1ns/100ps
module dcw_master_model (
    input wire logic clk_in,
    output logic tel_valid_out,
    output logic [1:0] tel_type_out,
    output logic [15:0] tel_word_out,
    output logic signed [15:0] tel_speed_out
);
    initial begin
        tel_valid_out = 1'b0;
        tel_type_out = 2'h0;
        tel_word_out = 16'hFFFF;
        tel_speed_out = 16'h0000;
    end

    // one telegram per call; the slot is idle for a cycle after it
    task send(input logic [15:0] w, input logic [15:0] s,
              input logic [1:0] t);
        @(posedge clk_in);
        #1;
        tel_valid_out = 1'b1;
        tel_type_out = t;
        tel_word_out = w;
        tel_speed_out = s;
        @(posedge clk_in);
        #1;
        tel_valid_out = 1'b0;
        // stale slot data is inverted so it never passes for fresh data
        tel_word_out = ~w;
        tel_speed_out = ~s;
    endtask
endmodule

// File: verification/dcw_properties.sv
// concurrent checks on the decoder's ports
`timescale 1ns/100ps
module dcw_properties import dcw_pkg::*; (
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic speed_mode_in,
    input wire logic tel_valid_in,
    input wire logic [1:0] tel_type_in,
    input wire logic [15:0] tel_ctrl_word_in,
    input wire logic param_req_in,
    input wire logic param_we_in,
    input wire logic [15:0] param_number_in,
    input wire logic [15:0] param_wdata_in,
    input wire logic [7:0] fb_dip_in,
    input wire logic fb_module_present_in,
    input wire logic dyn_addr_in,
    input wire logic dcp_valid_in,
    input wire logic dcp_name_match_in,
    input wire logic [31:0] dcp_ip_in,
    input wire logic param_ack_out,
    input wire logic param_err_out,
    input wire logic [15:0] ctrl_word_out,
    input wire logic plc_control_out,
    input wire logic cmd_on_out,
    input wire logic cmd_no_coast_out,
    input wire logic cmd_no_quick_out,
    input wire logic cmd_enable_op_out,
    input wire logic fault_ack_out,
    input wire logic signed [15:0] speed_setpoint_out,
    input wire logic fb_module_active_out,
    input wire logic fb_onboard_active_out,
    input wire dcw_fb_src_t fb_source_out,
    input wire logic [31:0] ip_addr_out
);
    logic [2:0] up_r;
    // guard spans the two-flop release and the config capture
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            up_r <= 3'h0;
        end else if (up_r != 3'h4) begin
            up_r <= up_r + 3'h1;
        end
    end
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in || up_r != 3'h4);

    sequence tel_take_s;
        tel_valid_in && tel_type_in <= DCW_TEL_TYPE_MAX;
    endsequence
    sequence tel_plc_s;
        tel_take_s ##0 tel_ctrl_word_in[10];
    endsequence

    word_capture_a: assert property (tel_take_s |=>
        ctrl_word_out == $past(tel_ctrl_word_in))
        else $error("control word not captured");
    cmd_decode_a: assert property (tel_plc_s |-> ##2
        {cmd_enable_op_out, cmd_no_quick_out, cmd_no_coast_out,
        cmd_on_out} == $past(tel_ctrl_word_in[3:0], 2) && plc_control_out)
        else $error("command bits wrong");
    plc_ignore_a: assert property (tel_take_s ##0
        !tel_ctrl_word_in[10] |-> ##2 !plc_control_out &&
        $stable(cmd_on_out) && $stable(cmd_enable_op_out))
        else $error("word evaluated without plc control");
    fault_edge_a: assert property ($rose(fault_ack_out) |->
        $past(tel_valid_in && tel_ctrl_word_in[7], 3) ||
        $past(param_req_in && param_we_in && param_wdata_in[7], 3))
        else $error("fault ack without cause");
    fault_pulse_a: assert property (fault_ack_out |=>
        !fault_ack_out) else $error("fault ack not a pulse");
    param_ack_a: assert property (param_req_in |=> param_ack_out &&
        param_err_out == $past(param_number_in != DCW_CTRL_PARAM_NUM))
        else $error("parameter answer wrong");
    sp_zero_a: assert property (tel_plc_s ##0 (speed_mode_in &&
        !tel_ctrl_word_in[6]) |-> ##3 speed_setpoint_out == 16'h0000)
        else $error("setpoint not forced to zero");
    fb_off_a: assert property (!fb_dip_in[7] &&
        fb_dip_in != 8'h00 |=> !fb_module_active_out &&
        !fb_onboard_active_out && fb_source_out == DCW_FB_FORCED_OFF)
        else $error("fieldbus not forced off");
    fb_on_a: assert property (fb_dip_in[7] |=>
        fb_module_active_out == $past(fb_module_present_in) &&
        fb_onboard_active_out != $past(fb_module_present_in))
        else $error("wrong fieldbus activated");
    fb_param_a: assert property (fb_dip_in == 8'h00 |=>
        fb_source_out == DCW_FB_FROM_PARAM)
        else $error("activation source not parameter");
    dcp_take_a: assert property (dcp_valid_in &&
        dcp_name_match_in && dyn_addr_in |=> ip_addr_out == $past(dcp_ip_in))
        else $error("assigned address not taken");
endmodule

// File: verification/dcw_decoder_bench.sv
// self-checking bench for the drive control word decoder
`timescale 1ns/100ps
module dcw_decoder_bench;
    import dcw_pkg::*;
    logic sys_clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic speed_mode_in = 1'b1;
    logic tel_valid_in, param_req_in = 1'b0, param_we_in = 1'b0;
    logic [1:0] tel_type_in;
    logic [15:0] tel_ctrl_word_in, param_number_in = 16'h0000;
    logic [15:0] param_wdata_in = 16'h0000;
    logic signed [15:0] tel_speed_in, jog_pos_speed_in = 16'h0000;
    logic signed [15:0] jog_neg_speed_in = 16'hFFE2;
    logic [15:0] accel_rate_in = 16'h0032, decel_rate_in = 16'h0032;
    logic [7:0] fb_dip_in = 8'h00;
    logic fb_module_present_in = 1'b1, fb_param_active_in = 1'b1;
    logic dyn_addr_in = 1'b1, dcp_valid_in = 1'b0, dcp_name_match_in = 1'b0;
    logic [31:0] static_ip_in = 32'h0A000001, static_mask_in = 32'hFFFFFF00;
    logic [31:0] static_gw_in = 32'h0A0000FE, dcp_ip_in = 32'hC0A80005;
    logic [31:0] dcp_mask_in = 32'hFFFF0000, dcp_gw_in = 32'hC0A80001;
    logic param_ack_out, param_err_out, plc_control_out, cmd_on_out;
    logic cmd_no_coast_out, cmd_no_quick_out, cmd_enable_op_out;
    logic fault_ack_out, jog_pos_out, jog_neg_out;
    logic fb_module_active_out, fb_onboard_active_out;
    logic [15:0] param_rdata_out, ctrl_word_out;
    logic signed [15:0] speed_setpoint_out;
    dcw_fb_src_t fb_source_out;
    logic [31:0] ip_addr_out, subnet_mask_out, gateway_out;
    int fails = 0;
    int tests_run = 0;

    always #5 sys_clk_in = ~sys_clk_in;

    dcw_master_model dcw_master_model_inst (.clk_in(sys_clk_in),
        .tel_valid_out(tel_valid_in), .tel_type_out(tel_type_in),
        .tel_word_out(tel_ctrl_word_in), .tel_speed_out(tel_speed_in));
    dcw_decoder dcw_decoder_inst (.sys_clk_in, .rstn_in, .speed_mode_in,
        .tel_valid_in, .tel_type_in, .tel_ctrl_word_in, .tel_speed_in,
        .param_req_in, .param_we_in, .param_number_in, .param_wdata_in,
        .jog_pos_speed_in, .jog_neg_speed_in, .accel_rate_in,
        .decel_rate_in, .fb_dip_in, .fb_module_present_in,
        .fb_param_active_in, .dyn_addr_in, .static_ip_in, .static_mask_in,
        .static_gw_in, .dcp_valid_in, .dcp_name_match_in, .dcp_ip_in,
        .dcp_mask_in, .dcp_gw_in, .param_ack_out, .param_err_out,
        .param_rdata_out, .ctrl_word_out, .plc_control_out, .cmd_on_out,
        .cmd_no_coast_out, .cmd_no_quick_out, .cmd_enable_op_out,
        .fault_ack_out, .jog_pos_out, .jog_neg_out, .speed_setpoint_out,
        .fb_module_active_out, .fb_onboard_active_out, .fb_source_out,
        .ip_addr_out, .subnet_mask_out, .gateway_out);

    task check(input string n, input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task nx(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask
    task acc(input logic we, input logic [15:0] num, wd);
        @(posedge sys_clk_in);
        #1;
        param_req_in = 1'b1;
        param_we_in = we;
        param_number_in = num;
        param_wdata_in = wd;
        nx(1);
        param_req_in = 1'b0;
        check("param ack", param_ack_out, 1'b1);
    endtask
    // returns when the evaluated word is visible
    task tel(input logic [15:0] w, s, input logic [1:0] t);
        dcw_master_model_inst.send(w, s, t);
        nx(1);
    endtask
    function logic [3:0] cmds();
        return {cmd_enable_op_out, cmd_no_quick_out, cmd_no_coast_out,
            cmd_on_out};
    endfunction
    task print_verdict();
        if (fails == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        #300000;
        fails++;
        print_verdict();
    end

    initial begin
        nx(10);
        rstn_in = 1'b1;
        nx(4);
        check("static ip", ip_addr_out, static_ip_in);
        acc(1'b0, DCW_CTRL_PARAM_NUM, 16'h0000);
        check("reset word", param_rdata_out, DCW_CTRL_RESET);
        acc(1'b0, 16'h0001, 16'h0000);
        check("unmapped err", param_err_out, 1'b1);
        acc(1'b1, DCW_CTRL_PARAM_NUM, 16'h047F);
        nx(1);
        check("param cmds", cmds(), 4'hF);
        acc(1'b0, DCW_CTRL_PARAM_NUM, 16'h0000);
        check("word readback", param_rdata_out, 16'h047F);
        tel(16'h04BF, 16'h0000, 2'h0);
        nx(1);
        check("fault rise", fault_ack_out, 1'b1);
        tel(16'h04BF, 16'h0000, 2'h0);
        nx(1);
        check("fault level", fault_ack_out, 1'b0);
        tel(16'h047F, 16'h0064, 2'h0);
        nx(1);
        check("sp jump", speed_setpoint_out, 16'h0064);
        tel(16'h043F, 16'h0064, 2'h0);
        nx(1);
        check("sp off", speed_setpoint_out, 16'h0000);
        // jump back up so the freeze below has a speed to hold
        tel(16'h047F, 16'h0064, 2'h0);
        tel(16'h044F, 16'h0000, 2'h0);
        nx(1100);
        check("frozen", speed_setpoint_out, 16'h0064);
        tel(16'h046F, 16'h0064, 2'h0);
        nx(2100);
        check("ramp down", speed_setpoint_out, 16'h0000);
        tel(16'h047F, 16'h0064, 2'h0);
        nx(2100);
        check("ramp up", speed_setpoint_out, 16'h0064);
        jog_pos_speed_in = 16'h001E;
        tel(16'h057F, 16'h0064, 2'h0);
        check("jog pos", jog_pos_out, 1'b1);
        nx(2100);
        check("jog speed", speed_setpoint_out, 16'h001E);
        tel(16'h067F, 16'h0000, 2'h0);
        check("jog neg", {jog_neg_out, jog_pos_out}, 2'h2);
        speed_mode_in = 1'b0;
        nx(1);
        check("mode gate", jog_neg_out, 1'b0);
        speed_mode_in = 1'b1;
        tel(16'h0000, 16'h0000, 2'h1);
        check("plc off", {plc_control_out, cmd_on_out}, 2'h1);
        tel(16'hFC0E, 16'h0000, 2'h2);
        check("high bits", {plc_control_out, cmds()}, 5'h1E);
        tel(16'h1234, 16'h0000, 2'h3);
        check("type three", ctrl_word_out, 16'hFC0E);
        fb_dip_in = 8'h80;
        nx(2);
        check("module on", {fb_module_active_out, fb_onboard_active_out},
            2'h2);
        fb_module_present_in = 1'b0;
        nx(2);
        check("onboard on", {fb_module_active_out, fb_onboard_active_out},
            2'h1);
        fb_dip_in = 8'h01;
        nx(2);
        check("forced off", fb_source_out, DCW_FB_FORCED_OFF);
        check("all off", fb_onboard_active_out, 1'b0);
        fb_dip_in = 8'h00;
        nx(2);
        check("param src", fb_source_out, DCW_FB_FROM_PARAM);
        check("param on", fb_onboard_active_out, 1'b1);
        fb_param_active_in = 1'b0;
        nx(2);
        check("param off", fb_onboard_active_out, 1'b0);
        fb_param_active_in = 1'b1;
        nx(2);
        check("param stays off", fb_onboard_active_out, 1'b0);
        dcp_valid_in = 1'b1;
        nx(1);
        dcp_valid_in = 1'b0;
        check("name miss", ip_addr_out, static_ip_in);
        dcp_valid_in = 1'b1;
        dcp_name_match_in = 1'b1;
        nx(1);
        dcp_valid_in = 1'b0;
        check("dcp addr", {ip_addr_out, subnet_mask_out}, {dcp_ip_in,
            dcp_mask_in});
        check("dcp gw", gateway_out, dcp_gw_in);
        print_verdict();
    end
endmodule

bind dcw_decoder dcw_properties dcw_properties_inst (.sys_clk_in, .rstn_in,
    .speed_mode_in, .tel_valid_in, .tel_type_in, .tel_ctrl_word_in,
    .param_req_in, .param_we_in, .param_number_in, .param_wdata_in,
    .fb_dip_in, .fb_module_present_in, .dyn_addr_in, .dcp_valid_in,
    .dcp_name_match_in, .dcp_ip_in, .param_ack_out, .param_err_out,
    .ctrl_word_out, .plc_control_out, .cmd_on_out, .cmd_no_coast_out,
    .cmd_no_quick_out, .cmd_enable_op_out, .fault_ack_out,
    .speed_setpoint_out, .fb_module_active_out, .fb_onboard_active_out,
    .fb_source_out, .ip_addr_out);
